// ---- rts_pkg.sv ----
// Package: constants, types and helpers for the ramp time selector
// Functional notes
// - Four acceleration and four deceleration times are held, and one pair is active at a time.
// - An input terminal set to function 07h is select bit one; one set to 1Ah is select bit two.
// - Select bits off/off, one only, two only and both pick pairs one, two, three and four.
// - Select changes are accepted while running and take effect without a stop.
// - With automatic switching on, the pair changes when output frequency reaches the threshold.
// - A switching threshold of zero turns automatic switching off; any other value turns it on.
// - Automatic switching uses pair four below the threshold and pair one at or above it.
// - With an analog input set to function 05h, pair one's acceleration time is scaled by its gain.
// - Four S-curve times are held: acceleration start and end, deceleration start and end.
// - Each ramp time is lengthened by half the sum of its own two S-curve times.
// - S-curve times range 0.00 to 2.50 s; three default to 0.20 s, deceleration end to 0.00 s.
// - Dwell holds the output at one level and time when starting and another when stopping.
// - Dwell levels range 0.0 to 400.0 Hz, dwell times 0.0 to 10.0 s, frozen while running.
package rts_pkg;
	localparam int FW = 13;
	localparam int TW = 16;
	localparam int SW = 8;
	localparam int CW = 20;
	localparam int GW = 8;
	localparam int FNW = 8;
	localparam int DTW = 8;
	localparam int DCW = 22;
	// Frequency in 0.1 Hz, ramp times in 0.1 s, S-curve times in 0.01 s
	localparam int FREQ_MAX_N = 4000;
	localparam logic [FW-1:0] FREQ_MAX = 13'hfa0;
	localparam logic [TW-1:0] ACC_MAX = 16'h1770;
	localparam logic [SW-1:0] SC_MAX = 8'hfa;
	localparam logic [SW-1:0] SC_DEF = 8'h14;
	localparam logic [SW-1:0] SC_DEC_END_DEF = 8'h00;
	localparam logic [DTW-1:0] HOLD_T_MAX = 8'h64;
	localparam logic [FNW-1:0] DI_SEL_ONE = 8'h07;
	localparam logic [FNW-1:0] DI_SEL_TWO = 8'h1a;
	localparam logic [FNW-1:0] AI_GAIN = 8'h05;
	localparam logic [GW-1:0] GAIN_UNITY = 8'h64;
	localparam int DS_TO_CS = 10;
	localparam int SUB_PER_DS = DS_TO_CS * FREQ_MAX_N;
	localparam int CLK_NS = 10;
	localparam int CS_NS = 10000000;
	localparam int CS_CYC = CS_NS / CLK_NS;

	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_HOLD_ST, ST_STOP, ST_HOLD_SP} rts_state_t;

	function automatic logic [15:0] rts_clamp(input logic [15:0] v, input logic [15:0] hi);
		return (v > hi) ? hi : v;
	endfunction

	function automatic logic [SW-1:0] rts_half_sum(input logic [SW-1:0] a, input logic [SW-1:0] b);
		logic [SW:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[SW:1];
	endfunction
endpackage

// ---- rts_ramp_core.sv ----
// Ramp core: frequency reference ramp with start and stop dwell
`timescale 1ns/1ps
`default_nettype none
module rts_ramp_core #(
	parameter int CS_CYCLES = rts_pkg::CS_CYC
) (
	// Clock and reset
	input wire logic                          clk_sys,
	input wire logic                          nrst,
	// Run command and reference
	input wire logic                          run_cmd,
	input wire logic [rts_pkg::FW-1:0]        freq_cmd,
	// Input terminals
	input wire logic [1:0]                    term_in,
	input wire logic [rts_pkg::FNW-1:0]       digital_input_function_select_one,
	input wire logic [rts_pkg::FNW-1:0]       digital_input_function_select_two,
	// Analog inputs
	input wire logic [rts_pkg::FNW-1:0]       analog_in_two_function,
	input wire logic [rts_pkg::FNW-1:0]       analog_in_three_function,
	input wire logic [rts_pkg::GW-1:0]        analog_two_gain,
	input wire logic [rts_pkg::GW-1:0]        analog_three_gain,
	// Ramp times
	input wire logic [rts_pkg::TW-1:0]        accel_time_one,
	input wire logic [rts_pkg::TW-1:0]        decel_time_one,
	input wire logic [rts_pkg::TW-1:0]        accel_time_two,
	input wire logic [rts_pkg::TW-1:0]        decel_time_two,
	input wire logic [rts_pkg::TW-1:0]        accel_time_three,
	input wire logic [rts_pkg::TW-1:0]        decel_time_three,
	input wire logic [rts_pkg::TW-1:0]        accel_time_four,
	input wire logic [rts_pkg::TW-1:0]        decel_time_four,
	input wire logic [rts_pkg::FW-1:0]        ramp_switch_frequency,
	// S-curve times
	input wire logic [rts_pkg::SW-1:0]        scurve_accel_start,
	input wire logic [rts_pkg::SW-1:0]        scurve_accel_end,
	input wire logic [rts_pkg::SW-1:0]        scurve_decel_start,
	input wire logic [rts_pkg::SW-1:0]        scurve_decel_end,
	// Dwell settings
	input wire logic [rts_pkg::FW-1:0]        start_hold_frequency,
	input wire logic [rts_pkg::DTW-1:0]       start_hold_time,
	input wire logic [rts_pkg::FW-1:0]        stop_hold_frequency,
	input wire logic [rts_pkg::DTW-1:0]       stop_hold_time,
	// Status and reference out
	output logic [rts_pkg::FW-1:0]            freq_out,
	output logic [1:0]                        active_pair,
	output logic                              hold_active,
	output logic                              running
);
	import rts_pkg::*;
	localparam int SUB_CYC = CS_CYCLES / FREQ_MAX_N;

	rts_rate_if rif ();

	rts_state_t     state_reg;
	rts_state_t     state_next;
	logic [FW-1:0]  tgt;
	logic           hold_enter;
	logic           start_done_reg;
	logic           stop_done_reg;
	logic [FW-1:0]  st_f_sh;
	logic [FW-1:0]  sp_f_sh;
	logic [DTW-1:0] st_t_sh;
	logic [DTW-1:0] sp_t_sh;
	logic [DTW-1:0] st_t_c;
	logic [DTW-1:0] sp_t_c;
	logic [DCW-1:0] dwell_cnt_reg;
	logic [DCW-1:0] dwell_lim;
	logic           dwell_up;
	logic           in_hold;

	rts_ramp_select u_sel (
		.clk_sys     (clk_sys),
		.nrst        (nrst),
		.rif         (rif.sel),
		.term_in     (term_in),
		.term_func   ({digital_input_function_select_two, digital_input_function_select_one}),
		.ai_func     ({analog_in_three_function, analog_in_two_function}),
		.ai_gain     ({analog_three_gain, analog_two_gain}),
		.accel_time  ({accel_time_four, accel_time_three, accel_time_two, accel_time_one}),
		.decel_time  ({decel_time_four, decel_time_three, decel_time_two, decel_time_one}),
		.switch_freq (ramp_switch_frequency),
		.scurve      ({scurve_decel_end, scurve_decel_start, scurve_accel_end, scurve_accel_start})
	);

	rts_step_timer #(
		.SUB_CYC (SUB_CYC)
	) u_tmr (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.rif     (rif.tmr)
	);

	assign rif.freq = freq_out;
	assign rif.running = running;
	assign active_pair = rif.pair;

	assign st_t_c = DTW'(rts_clamp(16'(start_hold_time), 16'(HOLD_T_MAX)));
	assign sp_t_c = DTW'(rts_clamp(16'(stop_hold_time), 16'(HOLD_T_MAX)));
	assign in_hold = (state_reg == ST_HOLD_ST) || (state_reg == ST_HOLD_SP);
	assign dwell_lim = DCW'((state_reg == ST_HOLD_SP) ? sp_t_sh : st_t_sh) * DCW'(SUB_PER_DS);
	assign dwell_up = dwell_cnt_reg >= dwell_lim;

	always_comb begin
		tgt = freq_out;
		if (state_reg == ST_RUN) begin
			tgt = FW'(rts_clamp(16'(freq_cmd), 16'(FREQ_MAX)));
		end else if (state_reg == ST_STOP) begin
			tgt = '0;
		end
	end

	// Holding stops the step in the same cycle, so the output never overshoots the dwell level
	assign rif.step_en = (state_reg == ST_RUN || state_reg == ST_STOP) && freq_out != tgt
		&& !hold_enter;
	assign rif.rate_cs = (freq_out < tgt) ? rif.acc_cs : rif.dec_cs;

	always_comb begin
		state_next = state_reg;
		hold_enter = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (run_cmd) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!run_cmd) begin
					state_next = ST_STOP;
				end else if (!start_done_reg && freq_out >= st_f_sh) begin
					state_next = ST_HOLD_ST;
					hold_enter = 1'b1;
				end
			end
			ST_HOLD_ST: begin
				if (!run_cmd) begin
					state_next = ST_STOP;
				end else if (dwell_up) begin
					state_next = ST_RUN;
				end
			end
			// Stop dwell relies on the drive being set to ramp to a stop
			ST_STOP: begin
				if (run_cmd) begin
					state_next = ST_RUN;
				end else if (!stop_done_reg && freq_out <= sp_f_sh) begin
					state_next = ST_HOLD_SP;
					hold_enter = 1'b1;
				end else if (freq_out == '0) begin
					state_next = ST_IDLE;
				end
			end
			ST_HOLD_SP: begin
				if (dwell_up) begin
					state_next = ST_STOP;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			hold_active <= 1'b0;
			running <= 1'b0;
		end else begin
			state_reg <= state_next;
			hold_active <= (state_next == ST_HOLD_ST) || (state_next == ST_HOLD_SP);
			running <= (state_next != ST_IDLE);
		end
	end

	// Dwell settings are captured only while idle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_f_sh <= '0;
			sp_f_sh <= '0;
			st_t_sh <= '0;
			sp_t_sh <= '0;
		end else if (state_reg == ST_IDLE) begin
			st_f_sh <= FW'(rts_clamp(16'(start_hold_frequency), 16'(FREQ_MAX)));
			sp_f_sh <= FW'(rts_clamp(16'(stop_hold_frequency), 16'(FREQ_MAX)));
			st_t_sh <= st_t_c;
			sp_t_sh <= sp_t_c;
		end
	end

	// A zero dwell time marks its stage done before it is reached
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			start_done_reg <= 1'b1;
			stop_done_reg <= 1'b1;
		end else begin
			if (state_reg == ST_IDLE) begin
				start_done_reg <= (st_t_c == '0);
			end else if (state_reg == ST_HOLD_ST && dwell_up) begin
				start_done_reg <= 1'b1;
			end
			if (state_reg == ST_IDLE || state_reg == ST_RUN || state_reg == ST_HOLD_ST) begin
				stop_done_reg <= (sp_t_sh == '0);
			end else if (state_reg == ST_HOLD_SP && dwell_up) begin
				stop_done_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dwell_cnt_reg <= '0;
		end else if (!in_hold) begin
			dwell_cnt_reg <= '0;
		end else if (rif.subtick && !dwell_up) begin
			dwell_cnt_reg <= dwell_cnt_reg + 22'h000001;
		end
	end

	// One unit per step, always from the present value
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			freq_out <= '0;
		end else if (rif.step && rif.step_en) begin
			freq_out <= (freq_out < tgt) ? freq_out + 13'h0001 : freq_out - 13'h0001;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	freq_step_a: assert property ($changed(freq_out) |-> freq_out == $past(freq_out) + 13'h0001 || freq_out == $past(freq_out) - 13'h0001) else $error("reference moved by more than one unit");
	hold_freeze_a: assert property (in_hold && $past(in_hold) |-> $stable(freq_out)) else $error("reference moved during dwell");
	hold_wait_a: assert property (state_reg == ST_HOLD_ST && !dwell_up && run_cmd |=> state_reg == ST_HOLD_ST) else $error("start dwell left early");
	stop_hold_a: assert property (state_reg == ST_STOP && !run_cmd && !stop_done_reg && freq_out <= sp_f_sh |=> state_reg == ST_HOLD_SP ##1 hold_active) else $error("stop dwell not entered");
	skip_dwell_a: assert property (state_reg == ST_RUN && st_t_sh == '0 |=> state_reg != ST_HOLD_ST) else $error("zero-time dwell was held");
	dwell_lock_a: assert property (state_reg != ST_IDLE && $past(state_reg) != ST_IDLE |-> $stable(st_f_sh) && $stable(sp_f_sh) && $stable(st_t_sh) && $stable(sp_t_sh)) else $error("dwell settings changed while running");
	dwell_range_a: assert property (st_f_sh <= FREQ_MAX && sp_f_sh <= FREQ_MAX && st_t_sh <= HOLD_T_MAX && sp_t_sh <= HOLD_T_MAX) else $error("dwell setting out of range");
	run_accel_a: assert property (state_reg == ST_RUN && rif.step && rif.step_en && freq_out < tgt |=> freq_out == $past(freq_out) + 13'h0001) else $error("running ramp did not advance");
	idle_zero_a: assert property (state_reg == ST_IDLE |-> freq_out == '0 && !running) else $error("idle with nonzero reference");

	start_hold_c: cover property (state_reg == ST_RUN ##1 state_reg == ST_HOLD_ST);
	stop_hold_c: cover property (state_reg == ST_HOLD_SP ##1 state_reg == ST_STOP);
	auto_pair_c: cover property (state_reg == ST_RUN && rif.pair == 2'h3 ##1 rif.pair == 2'h0);
	restart_c: cover property (state_reg == ST_STOP ##1 state_reg == ST_RUN);
endmodule
`default_nettype wire

// ---- rts_ramp_select.sv ----
// Ramp selector: active pair, gain and S-curve lengthened ramp times
`timescale 1ns/1ps
`default_nettype none
module rts_ramp_select (
	// Clock and reset
	input wire logic                                  clk_sys,
	input wire logic                                  nrst,
	// Core side
	rts_rate_if.sel                                   rif,
	// Terminals
	input wire logic [1:0]                            term_in,
	input wire logic [1:0][rts_pkg::FNW-1:0]          term_func,
	// Analog gain
	input wire logic [1:0][rts_pkg::FNW-1:0]          ai_func,
	input wire logic [1:0][rts_pkg::GW-1:0]           ai_gain,
	// Settings
	input wire logic [3:0][rts_pkg::TW-1:0]           accel_time,
	input wire logic [3:0][rts_pkg::TW-1:0]           decel_time,
	input wire logic [rts_pkg::FW-1:0]                switch_freq,
	input wire logic [3:0][rts_pkg::SW-1:0]           scurve
);
	import rts_pkg::*;

	logic [3:0][SW-1:0] sc_reg;
	logic               sel_one;
	logic               sel_two;
	logic               gain_on;
	logic [GW-1:0]      gain;
	logic [1:0]         pair_next;
	logic [CW-1:0]      acc_base;
	logic [CW-1:0]      acc_next;
	logic [CW-1:0]      dec_next;
	logic [CW+GW-1:0]   acc_gain;

	function automatic logic term_hit(input logic [1:0] lvl, input logic [1:0][FNW-1:0] fn,
		input logic [FNW-1:0] code);
		return (lvl[0] && fn[0] == code) || (lvl[1] && fn[1] == code);
	endfunction

	always_comb begin
		sel_one = term_hit(term_in, term_func, DI_SEL_ONE);
		sel_two = term_hit(term_in, term_func, DI_SEL_TWO);
		pair_next = {sel_two, sel_one};
		// Terminals win over the automatic choice
		if (!sel_one && !sel_two && switch_freq != '0) begin
			pair_next = (rif.freq < switch_freq) ? 2'h3 : 2'h0;
		end
		gain_on = (ai_func[0] == AI_GAIN) || (ai_func[1] == AI_GAIN);
		gain = (ai_func[0] == AI_GAIN) ? ai_gain[0] : ai_gain[1];
		acc_base = CW'(rts_clamp(accel_time[pair_next], ACC_MAX)) * CW'(DS_TO_CS);
		acc_gain = (CW+GW)'(acc_base) * (CW+GW)'(gain) / (CW+GW)'(GAIN_UNITY);
		acc_next = ((gain_on && pair_next == 2'h0) ? CW'(acc_gain) : acc_base)
			+ CW'(rts_half_sum(sc_reg[0], sc_reg[1]));
		dec_next = CW'(rts_clamp(decel_time[pair_next], ACC_MAX)) * CW'(DS_TO_CS)
			+ CW'(rts_half_sum(sc_reg[2], sc_reg[3]));
	end

	// Registered every cycle, so a terminal change mid-ramp reaches the rate at once
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rif.pair <= 2'h0;
			rif.acc_cs <= '0;
			rif.dec_cs <= '0;
		end else begin
			rif.pair <= pair_next;
			rif.acc_cs <= acc_next;
			rif.dec_cs <= dec_next;
		end
	end

	// S-curve settings are only taken while stopped
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sc_reg <= {SC_DEC_END_DEF, SC_DEF, SC_DEF, SC_DEF};
		end else if (!rif.running) begin
			for (int i = 0; i < 4; i++) begin
				sc_reg[i] <= SW'(rts_clamp(16'(scurve[i]), 16'(SC_MAX)));
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	pair_map_a: assert property (sel_one && !sel_two |=> rif.pair == 2'h1) else $error("bit one must pick pair two");
	auto_low_a: assert property (!sel_one && !sel_two && switch_freq != '0 && rif.freq < switch_freq |=> rif.pair == 2'h3) else $error("below threshold must pick pair four");
	auto_off_a: assert property (!sel_one && !sel_two && switch_freq == '0 |=> rif.pair == 2'h0) else $error("zero threshold must keep pair one");
	sc_range_a: assert property (sc_reg[0] <= SC_MAX && sc_reg[1] <= SC_MAX && sc_reg[2] <= SC_MAX && sc_reg[3] <= SC_MAX) else $error("s-curve time out of range");
	sc_frozen_a: assert property ($past(rif.running) |-> $stable(sc_reg)) else $error("s-curve changed while running");
endmodule
`default_nettype wire

// ---- rts_rate_if.sv ----
// Interface: ramp rate signals shared by the core, selector and step timer
`timescale 1ns/1ps
`default_nettype none
interface rts_rate_if;
	logic [rts_pkg::FW-1:0] freq;
	logic                   running;
	logic [1:0]             pair;
	logic [rts_pkg::CW-1:0] acc_cs;
	logic [rts_pkg::CW-1:0] dec_cs;
	logic [rts_pkg::CW-1:0] rate_cs;
	logic                   step_en;
	logic                   step;
	logic                   subtick;
	modport sel (input freq, running, output pair, acc_cs, dec_cs);
	modport tmr (input rate_cs, step_en, output step, subtick);
	modport core (input pair, acc_cs, dec_cs, step, subtick, output freq, running, rate_cs, step_en);
endinterface
`default_nettype wire

// ---- rts_step_timer.sv ----
// Step timer: sub-tick prescaler and per-unit step interval counter
`timescale 1ns/1ps
`default_nettype none
module rts_step_timer #(
	parameter int SUB_CYC = 250
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Core side
	rts_rate_if.tmr  rif
);
	import rts_pkg::*;
	localparam logic [15:0] PRE_LAST = 16'(SUB_CYC - 1);

	logic [15:0]   pre_reg;
	logic [CW-1:0] cnt_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pre_reg <= 16'h0000;
			rif.subtick <= 1'b0;
		end else begin
			rif.subtick <= (pre_reg == PRE_LAST);
			pre_reg <= (pre_reg == PRE_LAST) ? 16'h0000 : pre_reg + 16'h0001;
		end
	end

	// Counter is kept across rate changes so a new rate applies from where the ramp stands
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
			rif.step <= 1'b0;
		end else begin
			rif.step <= 1'b0;
			if (!rif.step_en) begin
				cnt_reg <= '0;
			end else if (rif.subtick) begin
				if (cnt_reg + 20'h00001 >= rif.rate_cs) begin
					rif.step <= 1'b1;
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_reg + 20'h00001;
				end
			end
		end
	end

	step_tick_a: assert property (@(posedge clk_sys) disable iff (!nrst) rif.step |-> $past(rif.subtick)) else $error("step without sub-tick");
endmodule
`default_nettype wire

// ---- rts_term_model.sv ----
// Partner model: input terminals and run command as the far side drives them
`timescale 1ns/1ps
`default_nettype none
module rts_term_model (
	// Clock
	input wire logic       clk_sys,
	// Requests from the bench
	input wire logic [1:0] sel_req,
	input wire logic       run_req,
	// Terminal side
	output logic [1:0]     term_in,
	output logic           run_cmd
);
	initial begin
		term_in = 2'h0;
		run_cmd = 1'b0;
	end
	// Levels move only just after an edge, as a synchronised terminal would
	always @(posedge clk_sys) begin
		term_in <= sel_req;
		// Dropping the run level always asks for a ramp stop
		run_cmd <= run_req;
	end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Testbench: ramp core against a behavioural model of pair choice and step rate
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rts_pkg::*;
	logic clk_sys, nrst, run_req, run_cmd, hold_active, running, stopping;
	logic [1:0] sel_req, term_in, active_pair;
	logic [FW-1:0] freq_cmd, thr, freq_out, shf, phf;
	logic [FNW-1:0] fs0, fs1, af2, af3;
	logic [GW-1:0] g2, g3;
	logic [3:0][TW-1:0] acc, dec;
	logic [3:0][SW-1:0] sc;
	logic [DTW-1:0] sht, pht;
	logic [FNW-1:0] codes [3];
	int mismatches, n_tests, cyc, d, i, t0, prev, seen_hold;

	rts_term_model u_term (.clk_sys(clk_sys), .sel_req(sel_req), .run_req(run_req),
		.term_in(term_in), .run_cmd(run_cmd));
	// One subtick per cycle, so 0.01 s of ramp time spans 4000 clocks
	rts_ramp_core #(.CS_CYCLES(4000)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
		.run_cmd(run_cmd), .freq_cmd(freq_cmd), .term_in(term_in),
		.digital_input_function_select_one(fs0), .digital_input_function_select_two(fs1),
		.analog_in_two_function(af2), .analog_in_three_function(af3),
		.analog_two_gain(g2), .analog_three_gain(g3),
		.accel_time_one(acc[0]), .decel_time_one(dec[0]), .accel_time_two(acc[1]),
		.decel_time_two(dec[1]), .accel_time_three(acc[2]), .decel_time_three(dec[2]),
		.accel_time_four(acc[3]), .decel_time_four(dec[3]), .ramp_switch_frequency(thr),
		.scurve_accel_start(sc[0]), .scurve_accel_end(sc[1]),
		.scurve_decel_start(sc[2]), .scurve_decel_end(sc[3]),
		.start_hold_frequency(shf), .start_hold_time(sht),
		.stop_hold_frequency(phf), .stop_hold_time(pht),
		.freq_out(freq_out), .active_pair(active_pair), .hold_active(hold_active),
		.running(running));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Model of the pair choice: terminals first, then the frequency threshold
	function automatic logic [1:0] exp_pair();
		logic b1, b2;
		b1 = (fs0 == DI_SEL_ONE && term_in[0]) || (fs1 == DI_SEL_ONE && term_in[1]);
		b2 = (fs0 == DI_SEL_TWO && term_in[0]) || (fs1 == DI_SEL_TWO && term_in[1]);
		if (b1 || b2)
			return {b2, b1};
		if (thr != 0)
			return (freq_out < thr) ? 2'h3 : 2'h0;
		return 2'h0;
	endfunction

	// Measures one whole interval between steps; a partial one may mix two rates
	task automatic gap(input int rate);
		int v;
		v = freq_out;
		for (i = 0; i < 3000 && freq_out == v; i++) @(negedge clk_sys);
		v = freq_out;
		t0 = cyc;
		for (i = 0; i < 3000 && freq_out == v; i++) @(negedge clk_sys);
		d = cyc - t0;
		check(d >= rate - 1 && d <= rate + 1, 1, "step interval");
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			results();
		end
	end

	// The reference never jumps, whatever changes under it
	always @(negedge clk_sys) begin
		if (nrst && running) begin
			check((freq_out > prev + 1) || (freq_out + 1 < prev), 0, "freq jump");
			if (stopping && hold_active)
				seen_hold = 1;
		end
		prev = freq_out;
	end

	initial begin
		codes = '{DI_SEL_ONE, DI_SEL_TWO, 8'h00};
		{nrst, run_req, stopping, sel_req, freq_cmd, thr, shf, phf, sht, pht} = '0;
		{af2, af3, g2, g3, acc, dec, sc} = '0;
		fs0 = DI_SEL_ONE;
		fs1 = DI_SEL_TWO;
		void'($urandom(19));
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		@(negedge clk_sys);
		check({freq_out, active_pair, hold_active, running}, 0, "reset state");
		for (int k = 0; k < 16; k++) begin
			@(posedge clk_sys);
			sel_req <= 2'($urandom);
			fs0 <= codes[$urandom % 3];
			fs1 <= codes[$urandom % 3];
			thr <= ($urandom % 2) ? 13'h028 : 13'h000;
			repeat (4) @(negedge clk_sys);
			check(active_pair, exp_pair(), "pair select");
		end
		@(posedge clk_sys);
		{sel_req, thr} <= '0;
		fs0 <= DI_SEL_ONE;
		fs1 <= DI_SEL_TWO;
		acc <= {16'h0001, 16'h0001, 16'h0002, 16'h0001};
		dec <= {4{16'h0001}};
		sc <= {8'h00, 8'h00, 8'h28, 8'h14};
		{freq_cmd, shf, sht} <= {13'h01e, 13'h005, 8'h01};
		phf <= 13'h003;
		repeat (3) @(posedge clk_sys);
		run_req <= 1'b1;
		for (i = 0; i < 2000 && !hold_active; i++) @(negedge clk_sys);
		check(freq_out, 5, "start dwell level");
		t0 = cyc;
		for (i = 0; i < 41000 && hold_active; i++) @(negedge clk_sys);
		check(cyc - t0 >= 39997 && cyc - t0 <= 40003, 1, "start dwell time");
		gap(40);
		@(posedge clk_sys);
		af2 <= AI_GAIN;
		g2 <= 8'h32;
		gap(35);
		@(posedge clk_sys);
		sel_req <= 2'h1;
		gap(50);
		check(active_pair, 2'h1, "pair while running");
		for (i = 0; i < 3000 && freq_out != 30; i++) @(negedge clk_sys);
		@(posedge clk_sys);
		sel_req <= 2'h0;
		thr <= 13'h028;
		repeat (4) @(negedge clk_sys);
		check(active_pair, exp_pair(), "below threshold");
		@(posedge clk_sys);
		freq_cmd <= 13'h032;
		for (i = 0; i < 2000 && freq_out < 42; i++) @(negedge clk_sys);
		repeat (3) @(negedge clk_sys);
		check(active_pair, exp_pair(), "above threshold");
		@(posedge clk_sys);
		sel_req <= 2'h2;
		repeat (4) @(negedge clk_sys);
		check(active_pair, exp_pair(), "terminal override");
		@(posedge clk_sys);
		{sel_req, run_req} <= '0;
		stopping <= 1'b1;
		for (i = 0; i < 3000 && running; i++) @(negedge clk_sys);
		check({freq_out, running}, 0, "stopped at zero");
		check(seen_hold, 0, "zero time dwell skipped");
		results();
	end
endmodule
`default_nettype wire
